/* File: rtl/strap_cfg_defines.svh */
/*
 * Constants of the reset strap capture block: pin and field positions,
 * register offsets, reset values and timing counts.
 * Assumes inclusion by bare name from the rtl folder.
 */
`ifndef STRAP_CFG_DEFINES_SVH
`define STRAP_CFG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     40
`define STRAP_SETTLE_NS   200
`define STRAP_SETTLE_CYC  ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Pins
// ----------------------------------------------------------------------------
`define MEMIF_ADDR_W      20
`define HOST_DATA_W       32
`define HOST_NARROW_W     16
`define PIN_STRAP_MSB     19
`define PIN_STRAP_LSB     13
`define GP_STRAP_W        3

// Bit positions in the synchronised strap vector
`define SYNC_W            11
`define SY_ENDIAN         0
`define SY_WIDTH          1
`define SY_MEMCLK         2
`define SY_BOOT_LSB       3
`define SY_BOOT_MSB       6
`define SY_GP_LSB         7
`define SY_GP_MSB         9
`define SY_PCI_EN         10

// ----------------------------------------------------------------------------
// Boot source codes
// ----------------------------------------------------------------------------
`define BOOT_CODE_NONE    4'h0
`define BOOT_CODE_HOST    4'h1
`define BOOT_CODE_I2C_M   4'h5
`define BOOT_CODE_I2C_S   4'h6
`define BOOT_CODE_PCI     4'h7

// ----------------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------------
`define REG_STATUS_OFS    4'h0
`define REG_CONTROL_OFS   4'h4
`define DIV_RATIO_RST     8'h08
`define DIV_RATIO_W       8
`define ST_BOOT_LSB       0
`define ST_BOOT_MSB       3
`define ST_MEMCLK         4
`define ST_WIDTH          5
`define ST_ENDIAN         6
`define ST_GP_LSB         7
`define ST_GP_MSB         9
`define ST_PCI_EN         10
`define ST_NARROW         11
`define ST_VALID          12
`define ST_SRC_LSB        13
`define ST_SRC_MSB        15

`endif

/* File: rtl/strap_cfg_pkg.sv */
/*
 * Types of the reset strap capture block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package strap_cfg_pkg;

	typedef enum logic [2:0] {
		BOOT_NONE       = 3'h0,
		BOOT_HOST_PORT  = 3'h1,
		BOOT_I2C_SLAVE  = 3'h2,
		BOOT_I2C_MASTER = 3'h3,
		BOOT_PCI        = 3'h6,
		BOOT_RESERVED   = 3'h7
	} boot_source_t;

	typedef enum logic [1:0] {
		ST_SETTLE  = 2'b00,
		ST_CAPTURE = 2'b01,
		ST_RUN     = 2'b11
	} capture_state_t;

endpackage

`default_nettype wire

/* File: rtl/strap_sync.sv */
/*
 * Three-stage input synchroniser; a new level is passed on only once the
 * second and third stages agree.
 * Assumes asynchronous inputs and a clock enable that freezes all stages.
 */
`timescale 1ns/1ps
`default_nettype none

module strap_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] async_i,
	output var  logic [W-1:0] sync_o
);

	logic [W-1:0] meta;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_sync;

	assign next_sync = (stage2 == stage3) ? stage3 : sync_o;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta   <= '0;
			stage2 <= '0;
			stage3 <= '0;
			sync_o <= '0;
		end else if (ce_i) begin
			meta   <= async_i;
			stage2 <= meta;
			stage3 <= stage2;
			sync_o <= next_sync;
		end
	end

endmodule

`default_nettype wire

/* File: rtl/reset_strap_config_capture.sv */
/*
 * Reset-time strap capture: samples configuration levels on the shared
 * memory address pins, holds them, decodes the operating modes and then
 * hands the pins to the memory interface as address outputs.
 * Assumes board pull resistors hold the strap levels while the pins are
 * undriven, and an Avalon-MM master for the two registers.
 */
//
// Overview of operation
// - Sample address pin straps to set modes
// - After capture pins drive memory address, tristatable
// - Boot code decode: none, host, I2C, PCI
// - Memory clock strap: low input, high divided
// - Divided clock default one eighth, software ratio
// - Width strap ignored unless PCI enable low
// - Narrow mode: upper sixteen data lines Hi-Z
// - Wide mode: all thirty-two data lines used
// - Endian strap: low big, high little
`timescale 1ns/1ps
`default_nettype none
`include "strap_cfg_defines.svh"

module reset_strap_config_capture (
	input  wire logic                              clk_i,
	input  wire logic                              sys_rst_i,
	input  wire logic                              ce_i,
	input  wire logic [`MEMIF_ADDR_W-1:0]          address_pin_i,
	output var  logic [`MEMIF_ADDR_W-1:0]          address_pin_o,
	output var  logic [`MEMIF_ADDR_W-1:0]          address_pin_oe_o,
	input  wire logic [`MEMIF_ADDR_W-1:0]          memif_addr_i,
	input  wire logic                              memif_addr_oe_i,
	input  wire logic [`GP_STRAP_W-1:0]            general_config_straps_i,
	input  wire logic                              pci_enable_strap_i,
	input  wire logic [`HOST_DATA_W-1:0]           host_port_data_i,
	input  wire logic                              host_port_data_oe_i,
	output var  logic [`HOST_DATA_W-1:0]           host_port_data_o,
	output var  logic [`HOST_DATA_W-1:0]           host_port_data_oe_o,
	output var  logic [3:0]                        boot_source_select_o,
	output var  strap_cfg_pkg::boot_source_t       boot_source_o,
	output var  logic                              memif_clock_source_select_o,
	output var  logic                              divided_system_clock_o,
	output var  logic                              host_port_narrow_mode_o,
	output var  logic                              host_port_wide_mode_o,
	output var  logic                              byte_order_select_o,
	output var  logic [`GP_STRAP_W-1:0]            general_config_straps_o,
	output var  logic                              config_valid_o,
	input  wire logic [3:0]                        avs_address_i,
	input  wire logic                              avs_read_i,
	input  wire logic                              avs_write_i,
	input  wire logic [31:0]                       avs_writedata_i,
	input  wire logic [3:0]                        avs_byteenable_i,
	output var  logic [31:0]                       avs_readdata_o,
	output var  logic                              avs_waitrequest_o
);
	import strap_cfg_pkg::*;

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	function automatic boot_source_t decode_boot(input logic [3:0] code);
		case (code)
			`BOOT_CODE_NONE:  decode_boot = BOOT_NONE;
			`BOOT_CODE_HOST:  decode_boot = BOOT_HOST_PORT;
			`BOOT_CODE_I2C_M: decode_boot = BOOT_I2C_MASTER;
			`BOOT_CODE_I2C_S: decode_boot = BOOT_I2C_SLAVE;
			`BOOT_CODE_PCI:   decode_boot = BOOT_PCI;
			default:          decode_boot = BOOT_RESERVED;
		endcase
	endfunction

	localparam logic [3:0] SETTLE_LAST = 4'(`STRAP_SETTLE_CYC - 1);

	capture_state_t            state;
	capture_state_t            next_state;
	logic [3:0]                settle_cnt;
	logic [`SYNC_W-1:0]        strap_raw;
	logic [`SYNC_W-1:0]        strap_sync;
	logic [`DIV_RATIO_W-1:0]   div_ratio;
	logic [`DIV_RATIO_W-1:0]   div_cnt;
	logic [`DIV_RATIO_W-1:0]   div_half;
	logic [`DIV_RATIO_W-1:0]   next_div_cnt;
	logic                      div_wrap;
	logic                      capture_now;
	logic                      narrow_now;
	logic                      bus_req;
	logic                      bus_done;
	logic                      sel_status;
	logic                      sel_control;
	logic [31:0]               status_word;
	logic [31:0]               read_word;
	logic                      pci_enable_held;

	// ------------------------------------------------------------------------
	// Strap sampling
	// ------------------------------------------------------------------------
	assign strap_raw = {pci_enable_strap_i, general_config_straps_i,
		address_pin_i[`PIN_STRAP_MSB:`PIN_STRAP_LSB]};

	strap_sync #(
		.W (`SYNC_W)
	) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.async_i   (strap_raw),
		.sync_o    (strap_sync)
	);

	assign capture_now = (state == ST_CAPTURE);
	// Width strap only counts with the host port enabled
	assign narrow_now  = strap_sync[`SY_PCI_EN] | ~strap_sync[`SY_WIDTH];

	always_comb begin
		next_state = state;
		unique case (state)
			ST_SETTLE:  if (settle_cnt == SETTLE_LAST) next_state = ST_CAPTURE;
			ST_CAPTURE: next_state = ST_RUN;
			ST_RUN:     next_state = ST_RUN;
			default:    next_state = ST_SETTLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state      <= ST_SETTLE;
			settle_cnt <= 4'h0;
		end else if (ce_i) begin
			state      <= next_state;
			settle_cnt <= (state == ST_SETTLE) ? settle_cnt + 4'h1 : settle_cnt;
		end
	end

	// Captured once, then frozen until the next reset
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			boot_source_select_o        <= `BOOT_CODE_NONE;
			boot_source_o               <= BOOT_NONE;
			memif_clock_source_select_o <= 1'b0;
			host_port_narrow_mode_o     <= 1'b1;
			host_port_wide_mode_o       <= 1'b0;
			byte_order_select_o         <= 1'b1;
			general_config_straps_o     <= '0;
			config_valid_o              <= 1'b0;
			pci_enable_held             <= 1'b0;
		end else if (ce_i && capture_now) begin
			boot_source_select_o        <= strap_sync[`SY_BOOT_MSB:`SY_BOOT_LSB];
			boot_source_o               <= decode_boot(strap_sync[`SY_BOOT_MSB:`SY_BOOT_LSB]);
			memif_clock_source_select_o <= strap_sync[`SY_MEMCLK];
			host_port_narrow_mode_o     <= narrow_now;
			host_port_wide_mode_o       <= ~narrow_now;
			byte_order_select_o         <= strap_sync[`SY_ENDIAN];
			general_config_straps_o     <= strap_sync[`SY_GP_MSB:`SY_GP_LSB];
			config_valid_o              <= 1'b1;
			pci_enable_held             <= strap_sync[`SY_PCI_EN];
		end
	end

	// ------------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			address_pin_o       <= '0;
			address_pin_oe_o    <= '0;
			host_port_data_o    <= '0;
			host_port_data_oe_o <= '0;
		end else if (ce_i) begin
			address_pin_o       <= memif_addr_i;
			address_pin_oe_o    <= {`MEMIF_ADDR_W{memif_addr_oe_i && state == ST_RUN}};
			host_port_data_o    <= host_port_data_i;
			host_port_data_oe_o <= {{(`HOST_DATA_W-`HOST_NARROW_W){host_port_data_oe_i && host_port_wide_mode_o}},
				{`HOST_NARROW_W{host_port_data_oe_i}}};
		end
	end

	// ------------------------------------------------------------------------
	// Divided system clock
	// ------------------------------------------------------------------------
	assign div_half     = (div_ratio > 8'h01) ? (div_ratio >> 1) : 8'h01;
	assign div_wrap     = (div_cnt >= div_half - 8'h01);
	assign next_div_cnt = div_wrap ? 8'h00 : div_cnt + 8'h01;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_cnt                <= 8'h00;
			divided_system_clock_o <= 1'b0;
		end else if (ce_i) begin
			div_cnt                <= next_div_cnt;
			divided_system_clock_o <= divided_system_clock_o ^ div_wrap;
		end
	end

	// ------------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------------
	assign bus_req     = avs_read_i | avs_write_i;
	assign bus_done    = bus_req & ~avs_waitrequest_o;
	assign sel_status  = (avs_address_i == `REG_STATUS_OFS);
	assign sel_control = (avs_address_i == `REG_CONTROL_OFS);

	always_comb begin
		status_word                            = 32'h0000_0000;
		status_word[`ST_BOOT_MSB:`ST_BOOT_LSB] = boot_source_select_o;
		status_word[`ST_MEMCLK]                = memif_clock_source_select_o;
		status_word[`ST_WIDTH]                 = host_port_wide_mode_o;
		status_word[`ST_ENDIAN]                = byte_order_select_o;
		status_word[`ST_GP_MSB:`ST_GP_LSB]     = general_config_straps_o;
		status_word[`ST_PCI_EN]                = pci_enable_held;
		status_word[`ST_NARROW]                = host_port_narrow_mode_o;
		status_word[`ST_VALID]                 = config_valid_o;
		status_word[`ST_SRC_MSB:`ST_SRC_LSB]   = boot_source_o;
	end

	assign read_word = sel_status  ? status_word :
	                   sel_control ? {24'h00_0000, div_ratio} : 32'h0000_0000;

	// One wait cycle per access; a write lands at the edge after waitrequest is released
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
			div_ratio         <= `DIV_RATIO_RST;
		end else if (ce_i) begin
			avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
			if (bus_req && avs_waitrequest_o)
				avs_readdata_o <= read_word;
			if (bus_done && avs_write_i && sel_control && avs_byteenable_i[0])
				div_ratio <= avs_writedata_i[`DIV_RATIO_W-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence seq_capture;
		ce_i && capture_now;
	endsequence

	sequence seq_bus_wait;
		ce_i && bus_req && avs_waitrequest_o;
	endsequence

	AST_STRAP_TAKEN: assert property (seq_capture |=> boot_source_select_o == $past(strap_sync[6:3]))
		else $error("boot select not taken from synchronised straps");
	AST_PINS_HIZ: assert property (state != ST_RUN |=> address_pin_oe_o == '0)
		else $error("address pins driven before straps were captured");
	AST_BOOT_I2C: assert property (config_valid_o && boot_source_select_o == 4'h5 |-> boot_source_o == BOOT_I2C_MASTER)
		else $error("code 0101 not decoded as I2C master boot");
	AST_MEMCLK: assert property (seq_capture |=> memif_clock_source_select_o == $past(strap_sync[2]))
		else $error("memory clock select does not follow its strap");
	AST_RATIO_WRITE: assert property (ce_i && bus_done && avs_write_i && sel_control && avs_byteenable_i[0]
		|=> div_ratio == $past(avs_writedata_i[7:0]))
		else $error("divider ratio not updated by write");
	AST_WIDTH_IGNORED: assert property (seq_capture ##1 strap_sync[10] |-> host_port_narrow_mode_o)
		else $error("width strap honoured while host port disabled");
	AST_NARROW_HIZ: assert property (ce_i && host_port_narrow_mode_o |=> host_port_data_oe_o[31:16] == 16'h0000)
		else $error("upper host data lines driven in narrow mode");
	AST_WIDE_DRIVE: assert property (ce_i && host_port_wide_mode_o && host_port_data_oe_i |=> &host_port_data_oe_o)
		else $error("wide mode does not drive all host data lines");
	AST_ENDIAN: assert property (seq_capture |=> byte_order_select_o == $past(strap_sync[0]))
		else $error("byte order does not follow its strap");
	AST_HOLD: assert property (state == ST_RUN |=> $stable(boot_source_select_o) && $stable(byte_order_select_o))
		else $error("captured strap changed after capture");
	AST_BUS_ACK: assert property (seq_bus_wait |=> !avs_waitrequest_o)
		else $error("bus request not answered after one wait cycle");

endmodule

`default_nettype wire

/* File: bench/strap_board_model.sv */
/*
 * Board model for the strap pins: pull resistors set by the bench.
 * Assumes a pin shows the device level while its enable is high.
 */
`timescale 1ns/1ps
`default_nettype none

module strap_board_model (
	input  wire logic [10:0] strap_set_i,
	input  wire logic [19:0] pin_drive_i,
	input  wire logic [19:0] pin_oe_i,
	output var  logic [19:0] pin_level_o,
	output var  logic [2:0]  general_config_straps_o,
	output var  logic        pci_enable_strap_o
);
	// ------------------------------------------------------------------
	// Pull levels
	// ------------------------------------------------------------------
	logic [19:0] pull_level;

	// Straps on 19:13, the rest pulled low; reserved codes only on command
	assign pull_level = {strap_set_i[6:0], 13'h0000};
	assign pin_level_o = (pin_oe_i & pin_drive_i) | (~pin_oe_i & pull_level);
	assign general_config_straps_o = strap_set_i[9:7];
	assign pci_enable_strap_o = strap_set_i[10];
endmodule

`default_nettype wire

/* File: bench/reset_strap_config_capture_bench.sv */
/*
 * Self-checking bench of the strap capture block and its two registers.
 * Assumes a 25 MHz clock and the board model on the address pins.
 */
`timescale 1ns/1ps
`default_nettype none

module reset_strap_config_capture_bench;
	import strap_cfg_pkg::*;
	logic         clk_i, sys_rst_i, ce_i, memif_addr_oe_i, pci_enable_strap_i, host_port_data_oe_i;
	logic [19:0]  address_pin_i, address_pin_o, address_pin_oe_o, memif_addr_i;
	logic [2:0]   general_config_straps_i, general_config_straps_o;
	logic [31:0]  host_port_data_i, host_port_data_o, host_port_data_oe_o, avs_writedata_i, avs_readdata_o;
	logic [3:0]   boot_source_select_o, avs_address_i, avs_byteenable_i;
	boot_source_t boot_source_o;
	logic         memif_clock_source_select_o, divided_system_clock_o, host_port_narrow_mode_o;
	logic         host_port_wide_mode_o, byte_order_select_o, config_valid_o;
	logic         avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [10:0]  strap_set;
	logic [31:0]  rdata;
	logic [10:0]  cases [6] = '{11'h001, 11'h28e, 11'h52b, 11'h3b4, 11'h43b, 11'h535};
	int           err_count, checked, cycles, n;

	reset_strap_config_capture u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
		.address_pin_i(address_pin_i), .address_pin_o(address_pin_o), .address_pin_oe_o(address_pin_oe_o),
		.memif_addr_i(memif_addr_i), .memif_addr_oe_i(memif_addr_oe_i),
		.general_config_straps_i(general_config_straps_i), .pci_enable_strap_i(pci_enable_strap_i),
		.host_port_data_i(host_port_data_i), .host_port_data_oe_i(host_port_data_oe_i),
		.host_port_data_o(host_port_data_o), .host_port_data_oe_o(host_port_data_oe_o),
		.boot_source_select_o(boot_source_select_o), .boot_source_o(boot_source_o),
		.memif_clock_source_select_o(memif_clock_source_select_o),
		.divided_system_clock_o(divided_system_clock_o), .host_port_narrow_mode_o(host_port_narrow_mode_o),
		.host_port_wide_mode_o(host_port_wide_mode_o), .byte_order_select_o(byte_order_select_o),
		.general_config_straps_o(general_config_straps_o), .config_valid_o(config_valid_o),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

	strap_board_model u_board (.strap_set_i(strap_set), .pin_drive_i(address_pin_o),
		.pin_oe_i(address_pin_oe_o), .pin_level_o(address_pin_i),
		.general_config_straps_o(general_config_straps_i), .pci_enable_strap_o(pci_enable_strap_i));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task final_report;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	function automatic boot_source_t dec(input logic [3:0] c);
		case (c)
			4'h0: return BOOT_NONE;
			4'h1: return BOOT_HOST_PORT;
			4'h5: return BOOT_I2C_MASTER;
			4'h6: return BOOT_I2C_SLAVE;
			4'h7: return BOOT_PCI;
			default: return BOOT_RESERVED;
		endcase
	endfunction

	// Avalon-MM access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata, input logic [3:0] be);
		int k;
		@(posedge clk_i);
		avs_address_i <= addr;
		avs_writedata_i <= wdata;
		avs_byteenable_i <= be;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0);
		rdata = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		cmp(k, 32'h0000_0002, "bus answer latency");
	endtask

	task run_reset;
		int k;
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (k = 0; k < 30 && config_valid_o !== 1'b1; k++) begin
			@(negedge clk_i);
			if (config_valid_o !== 1'b1 && address_pin_oe_o !== 20'h0_0000)
				cmp(address_pin_oe_o, 32'h0000_0000, "pins driven during capture");
		end
		cmp(config_valid_o, 1'b1, "capture done");
	endtask

	task wait_lvl(input logic v, inout int cnt);
		for (int k = 0; k < 50 && divided_system_clock_o !== v; k++) begin
			@(negedge clk_i);
			cnt++;
		end
	endtask

	task clk_period(output int p);
		p = 0;
		wait_lvl(1'b0, p);
		wait_lvl(1'b1, p);
		p = 0;
		wait_lvl(1'b0, p);
		wait_lvl(1'b1, p);
	endtask

	task strap_case(input logic [10:0] s);
		logic        wide;
		logic [31:0] exp;
		@(posedge clk_i);
		strap_set <= s;
		memif_addr_i <= {s, 9'h0ab};
		host_port_data_i <= {21'h00_0000, s} ^ 32'ha5a5_5a5a;
		memif_addr_oe_i <= 1'b1;
		run_reset;
		wide = s[1] & ~s[10];
		exp = {16'h0000, dec(s[6:3]), 1'b1, ~wide, s[10], s[9:7], s[0], wide, s[2], s[6:3]};
		cmp(boot_source_select_o, s[6:3], "boot code");
		cmp(boot_source_o, dec(s[6:3]), "decoded boot");
		cmp(memif_clock_source_select_o, s[2], "memory clock select");
		cmp({host_port_wide_mode_o, host_port_narrow_mode_o}, {wide, ~wide}, "host width");
		cmp(byte_order_select_o, s[0], "byte order");
		cmp(general_config_straps_o, s[9:7], "general straps");
		bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
		cmp(rdata, exp, "status");
		@(posedge clk_i);
		host_port_data_oe_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		cmp(host_port_data_oe_o, {{16{wide}}, 16'hffff}, "host data enables");
		cmp(host_port_data_o, host_port_data_i, "host data");
		cmp(address_pin_oe_o, 32'h000f_ffff, "address drive");
		cmp(address_pin_o, memif_addr_i, "address value");
		@(posedge clk_i);
		strap_set <= ~s;
		memif_addr_oe_i <= 1'b0;
		host_port_data_oe_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		cmp(address_pin_oe_o, 32'h0000_0000, "address released");
		bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
		cmp(rdata, exp, "status after pin change");
		$display("strap case %h done", s);
	endtask

	// ------------------------------------------------------------------
	// Clock, timeout and sequence
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			final_report;
		end
	end

	initial begin
		{err_count, checked, cycles} = '0;
		sys_rst_i = 1'b1;
		ce_i = 1'b1;
		strap_set = 11'h001;
		memif_addr_i = 20'h0_0000;
		memif_addr_oe_i = 1'b0;
		host_port_data_i = 32'h0000_0000;
		host_port_data_oe_i = 1'b0;
		{avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 6; i++)
			strap_case(cases[i]);
		bus(1'b0, 4'h4, 32'h0000_0000, 4'hf);
		cmp(rdata, 32'h0000_0008, "ratio reset value");
		clk_period(n);
		cmp(n, 32'h0000_0008, "default divided period");
		bus(1'b1, 4'h4, 32'h0000_0004, 4'hf);
		clk_period(n);
		cmp(n, 32'h0000_0004, "new divided period");
		bus(1'b1, 4'h4, 32'h0000_0002, 4'he);
		bus(1'b0, 4'h4, 32'h0000_0000, 4'hf);
		cmp(rdata, 32'h0000_0004, "masked ratio write");
		bus(1'b1, 4'h8, 32'hffff_ffff, 4'hf);
		bus(1'b0, 4'h8, 32'h0000_0000, 4'hf);
		cmp(rdata, 32'h0000_0000, "unmapped read");
		@(posedge clk_i);
		ce_i <= 1'b0;
		@(negedge clk_i);
		n = divided_system_clock_o;
		repeat (12) @(negedge clk_i);
		cmp(divided_system_clock_o, n, "divided clock frozen by enable");
		@(posedge clk_i);
		ce_i <= 1'b1;
		$display("register test done");
		final_report;
	end
endmodule

`default_nettype wire
